// >>> core/esf_defs.vh
// Constants for the electronic shaft follower
`ifndef ESF_DEFS_VH
`define ESF_DEFS_VH

`define ESF_CLK_PERIOD_NS   25
`define ESF_CTRL_CYCLE_NS   1000000
`define ESF_TIMEOUT_CYCLES  4

`define ESF_ADDR_W          8
`define ESF_OFF_CTRL        8'h00
`define ESF_OFF_MASTER      8'h04
`define ESF_OFF_GEARNUM     8'h08
`define ESF_OFF_GEARDEN     8'h0C
`define ESF_OFF_FILTER      8'h10
`define ESF_OFF_AUXSEL      8'h14
`define ESF_OFF_STATUS      8'h18
`define ESF_OFF_SLAVEPOS    8'h1C
`define ESF_OFF_MAINPOS     8'h20
`define ESF_OFF_REVISION    8'h24

`define ESF_CTRL_FOLLOW     0
`define ESF_CTRL_DECEL      1
`define ESF_CTRL_IMMED      2
`define ESF_CTRL_TORQUE     3
`define ESF_CTRL_LINKEN     4
`define ESF_CTRL_RST        32'h0000_0000

`define ESF_MSEL_LSB        0
`define ESF_MSEL_MSB        2
`define ESF_MAXIS_LSB       8
`define ESF_MAXIS_MSB       12
`define ESF_MASTER_RST      32'h0000_0000

`define ESF_SRC_NONE        3'h0
`define ESF_SRC_LINK        3'h1
`define ESF_SRC_FEEDBACK    3'h3
`define ESF_SRC_COMMAND     3'h4

`define ESF_NUM_AXES        17
`define ESF_AXIS_MAX        5'h10
`define ESF_NUM_MAX         16'sh2710
`define ESF_NUM_MIN         -16'sh2710
`define ESF_DEN_MAX         16'h2710
`define ESF_GEARNUM_RST     32'h0000_0000
`define ESF_GEARDEN_RST     32'h0000_0000

`define ESF_FILT_SHIFT      8
`define ESF_FILTER_RST      32'h0000_0100

`define ESF_ST_ACK          0
`define ESF_ST_BUSY         1
`define ESF_ST_TIMEOUT      2
`define ESF_ST_STOPPED      3

`define ESF_REV_MIN_AUX     8'h15
`define ESF_REV_DEFAULT     8'h15

`define ESF_RESP_OKAY       2'h0
`define ESF_RESP_SLVERR     2'h2

`define ESF_FSM_IDLE        2'h0
`define ESF_FSM_FOLLOW      2'h1
`define ESF_FSM_STOPPED     2'h2

`endif

// >>> core/esf_follower.v
// Electronic shaft follower for one slave axis with AXI4-Lite registers
// Function
// - Follow master only while follow flag set
// - Master source 0 none, 3 feedback, 4 command
// - Slave = (main + aux) times output filter
// - Follow start sets acknowledged status flag
// - Follow flag off stops, clears busy
// - Deceleration stop acts as immediate stop
// - Main value = master movement times gear ratio
// - Numerator signed, negative reverses direction
// - Master position taken from previous cycle latch
// - Master axis number 0 to 16
// - Numerator range -10000..10000, default zero
// - Denominator 0..10000, zero treated as one
// - Settings refreshed, applied at follow start; filter and aux select apply at once
// - Slave lags master by one cycle
// - Aux value from link aux slot
// - In-unit aux source needs revision 1.5+
// - Torque option passes torque data out
// - Sync tick missing four cycles: timeout, stop
//
// Local design decisions: the AXI4-Lite register port and the address map.
`include "esf_defs.vh"
`default_nettype none

module esf_follower #(
	parameter [7:0]  UNIT_REV        = `ESF_REV_DEFAULT,
	parameter [31:0] CTRL_CYCLE_CLKS = `ESF_CTRL_CYCLE_NS / `ESF_CLK_PERIOD_NS
) (
	input  wire                            clock,
	input  wire                            rst,
	input  wire                            ce,
	input  wire [`ESF_ADDR_W-1:0]          s_axi_awaddr,
	input  wire                            s_axi_awvalid,
	output wire                            s_axi_awready,
	input  wire [31:0]                     s_axi_wdata,
	input  wire [3:0]                      s_axi_wstrb,
	input  wire                            s_axi_wvalid,
	output wire                            s_axi_wready,
	output reg  [1:0]                      s_axi_bresp,
	output reg                             s_axi_bvalid,
	input  wire                            s_axi_bready,
	input  wire [`ESF_ADDR_W-1:0]          s_axi_araddr,
	input  wire                            s_axi_arvalid,
	output wire                            s_axi_arready,
	output reg  [31:0]                     s_axi_rdata,
	output reg  [1:0]                      s_axi_rresp,
	output reg                             s_axi_rvalid,
	input  wire                            s_axi_rready,
	input  wire                            syncTick,
	input  wire [`ESF_NUM_AXES*32-1:0]     feedbackPos,
	input  wire [`ESF_NUM_AXES*32-1:0]     commandPos,
	input  wire [31:0]                     linkAuxPos,
	input  wire [15:0]                     linkTorqueFf,
	input  wire [15:0]                     linkTorqueLimit,
	output reg  [31:0]                     slavePos,
	output reg                             slavePosValid,
	output reg  [15:0]                     torqueFfOut,
	output reg  [15:0]                     torqueLimitOut,
	output reg                             torqueValid,
	output reg                             followAck,
	output reg                             axisBusy,
	output reg                             syncTimeout
);

	localparam [31:0] TIMEOUT_CLKS = CTRL_CYCLE_CLKS * `ESF_TIMEOUT_CYCLES;

	// Settings registers
	reg  [31:0] ctrlReg;
	reg  [31:0] masterReg;
	reg  [31:0] gearNumReg;
	reg  [31:0] gearDenReg;
	reg  [31:0] filterReg;
	reg  [31:0] auxSelReg;

	// Bus slave
	reg                    awHeld;
	reg                    wHeld;
	reg  [`ESF_ADDR_W-1:0] awAddr;
	reg  [31:0]            wData;
	reg  [3:0]             wStrb;
	wire                   doWrite = awHeld & wHeld & ~s_axi_bvalid;
	wire                   clearTimeout;
	reg                    wrHit;
	reg  [31:0]            rdMux;
	reg                    rdHit;

	assign s_axi_awready = ~awHeld;
	assign s_axi_wready  = ~wHeld;
	assign s_axi_arready = ~s_axi_rvalid;
	assign clearTimeout  = doWrite & (awAddr == `ESF_OFF_STATUS) & wStrb[0]
		& wData[`ESF_ST_TIMEOUT];

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer      i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
			end
		end
	endfunction

	always @* begin
		case (awAddr)
			`ESF_OFF_CTRL, `ESF_OFF_MASTER, `ESF_OFF_GEARNUM, `ESF_OFF_GEARDEN,
			`ESF_OFF_FILTER, `ESF_OFF_AUXSEL, `ESF_OFF_STATUS: wrHit = 1'b1;
			default: wrHit = 1'b0;
		endcase
	end

	always @(posedge clock) begin
		if (rst) begin
			awHeld       <= 1'b0;
			wHeld        <= 1'b0;
			awAddr       <= {`ESF_ADDR_W{1'b0}};
			wData        <= 32'h0000_0000;
			wStrb        <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ESF_RESP_OKAY;
			ctrlReg      <= `ESF_CTRL_RST;
			masterReg    <= `ESF_MASTER_RST;
			gearNumReg   <= `ESF_GEARNUM_RST;
			gearDenReg   <= `ESF_GEARDEN_RST;
			filterReg    <= `ESF_FILTER_RST;
			auxSelReg    <= 32'h0000_0000;
		end else if (ce) begin
			if (s_axi_awvalid & ~awHeld) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid & ~wHeld) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrHit ? `ESF_RESP_OKAY : `ESF_RESP_SLVERR;
				case (awAddr)
					`ESF_OFF_CTRL:    ctrlReg    <= merge(ctrlReg, wData, wStrb);
					`ESF_OFF_MASTER:  masterReg  <= merge(masterReg, wData, wStrb);
					`ESF_OFF_GEARNUM: gearNumReg <= merge(gearNumReg, wData, wStrb);
					`ESF_OFF_GEARDEN: gearDenReg <= merge(gearDenReg, wData, wStrb);
					`ESF_OFF_FILTER:  filterReg  <= merge(filterReg, wData, wStrb);
					`ESF_OFF_AUXSEL:  auxSelReg  <= merge(auxSelReg, wData, wStrb);
					default: ;
				endcase
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeld       <= 1'b0;
				wHeld        <= 1'b0;
			end
		end
	end

	// Control state
	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [31:0] cycleCnt;
	reg  [31:0] syncCnt;
	wire        cycleTick = (cycleCnt == CTRL_CYCLE_CLKS - 32'h1);
	reg  [2:0]  runSel;
	reg  [4:0]  runAxis;
	reg  signed [15:0] runNum;
	reg  [15:0] runDen;
	reg  signed [31:0] lastPos;
	reg  signed [31:0] prevPos;
	reg  signed [31:0] mainAcc;
	reg  signed [15:0] remainder;
	reg         calcStep;

	wire        followCmd = ctrlReg[`ESF_CTRL_FOLLOW];
	wire        stopReq   = ctrlReg[`ESF_CTRL_DECEL] | ctrlReg[`ESF_CTRL_IMMED];

	// Unpacked axis positions
	wire [31:0] fbArr  [0:`ESF_NUM_AXES-1];
	wire [31:0] cmdArr [0:`ESF_NUM_AXES-1];
	genvar g;
	generate
		for (g = 0; g < `ESF_NUM_AXES; g = g + 1) begin : gAxis
			assign fbArr[g]  = feedbackPos[g*32 +: 32];
			assign cmdArr[g] = commandPos[g*32 +: 32];
		end
	endgenerate

	// Settings offered now, gear numerator and denominator clamped to their accepted ranges
	wire [2:0]  cfgSel  = masterReg[`ESF_MSEL_MSB:`ESF_MSEL_LSB];
	wire [4:0]  cfgAxis = masterReg[`ESF_MAXIS_MSB:`ESF_MAXIS_LSB];
	wire signed [15:0] cfgNumRaw = gearNumReg[15:0];
	wire signed [15:0] cfgNum = (cfgNumRaw > `ESF_NUM_MAX) ? `ESF_NUM_MAX :
		(cfgNumRaw < `ESF_NUM_MIN) ? `ESF_NUM_MIN : cfgNumRaw;
	wire [15:0] cfgDenRaw = gearDenReg[15:0];
	wire [15:0] cfgDen = (cfgDenRaw > `ESF_DEN_MAX) ? `ESF_DEN_MAX : cfgDenRaw;

	// Selected master position; out-of-range axis or unknown source gives none
	reg         masterOk;
	reg  [31:0] masterNow;
	always @* begin
		masterOk  = (runAxis <= `ESF_AXIS_MAX);
		masterNow = 32'h0000_0000;
		case (runSel)
			`ESF_SRC_FEEDBACK: masterNow = masterOk ? fbArr[runAxis] : 32'h0000_0000;
			`ESF_SRC_COMMAND:  masterNow = masterOk ? cmdArr[runAxis] : 32'h0000_0000;
			default:           masterOk  = 1'b0;
		endcase
	end

	// Same-unit master at follow start, for seeding the latches
	wire [31:0] startPos = (cfgAxis > `ESF_AXIS_MAX) ? 32'h0000_0000 :
		(cfgSel == `ESF_SRC_FEEDBACK) ? fbArr[cfgAxis] :
		(cfgSel == `ESF_SRC_COMMAND) ? cmdArr[cfgAxis] : 32'h0000_0000;

	// Geared movement: uses the latch of the previous cycle, so a physical
	// master is seen one cycle late by the slave
	// Extend from the difference, not the latch, or a backwards move turns huge
	wire signed [31:0] moveDiff = lastPos - prevPos;
	wire signed [48:0] moveWide = {{17{moveDiff[31]}}, moveDiff};
	wire signed [48:0] numWide  = {{33{runNum[15]}}, runNum};
	wire signed [48:0] remWide  = {{33{remainder[15]}}, remainder};
	wire signed [48:0] denWide  = (runDen == 16'h0000) ? 49'sh1 :
		{33'h0, runDen};
	wire signed [48:0] gearProd = moveWide * numWide + remWide;
	wire signed [48:0] gearQuot = gearProd / denWide;
	wire signed [48:0] gearRem  = gearProd - gearQuot * denWide;

	// Auxiliary value: link slot, or a same-unit axis on new enough revisions
	reg  [31:0] auxNow;
	wire [4:0]  auxAxis = auxSelReg[`ESF_MAXIS_MSB:`ESF_MAXIS_LSB];
	wire        auxUnitOk = (UNIT_REV >= `ESF_REV_MIN_AUX) & (auxAxis <= `ESF_AXIS_MAX);
	always @* begin
		auxNow = 32'h0000_0000;
		case (auxSelReg[`ESF_MSEL_MSB:`ESF_MSEL_LSB])
			`ESF_SRC_LINK:     auxNow = linkAuxPos;
			`ESF_SRC_FEEDBACK: auxNow = auxUnitOk ? fbArr[auxAxis] : 32'h0000_0000;
			`ESF_SRC_COMMAND:  auxNow = auxUnitOk ? cmdArr[auxAxis] : 32'h0000_0000;
			default:           auxNow = 32'h0000_0000;
		endcase
	end

	// Output position; filter is fixed point with eight fraction bits
	wire signed [31:0] outSum   = mainAcc + auxNow;
	wire signed [48:0] filtProd = {{17{outSum[31]}}, outSum} *
		{{33{filterReg[15]}}, filterReg[15:0]};
	wire signed [48:0] filtOut  = filtProd >>> `ESF_FILT_SHIFT;

	always @* begin
		next_state = state;
		case (state)
			`ESF_FSM_IDLE:
				if (followCmd & ~syncTimeout)
					next_state = `ESF_FSM_FOLLOW;
			`ESF_FSM_FOLLOW:
				if (~followCmd)
					next_state = `ESF_FSM_IDLE;
				else if (stopReq | syncTimeout)
					next_state = `ESF_FSM_STOPPED;
			`ESF_FSM_STOPPED:
				if (~followCmd)
					next_state = `ESF_FSM_IDLE;
			default:
				next_state = `ESF_FSM_IDLE;
		endcase
	end

	always @(posedge clock) begin
		if (rst) begin
			state          <= `ESF_FSM_IDLE;
			cycleCnt       <= 32'h0000_0000;
			syncCnt        <= 32'h0000_0000;
			syncTimeout    <= 1'b0;
			runSel         <= `ESF_SRC_NONE;
			runAxis        <= 5'h00;
			runNum         <= 16'sh0000;
			runDen         <= 16'h0000;
			lastPos        <= 32'sh0000_0000;
			prevPos        <= 32'sh0000_0000;
			mainAcc        <= 32'sh0000_0000;
			remainder      <= 16'sh0000;
			calcStep       <= 1'b0;
			slavePos       <= 32'h0000_0000;
			slavePosValid  <= 1'b0;
			torqueFfOut    <= 16'h0000;
			torqueLimitOut <= 16'h0000;
			torqueValid    <= 1'b0;
			followAck      <= 1'b0;
			axisBusy       <= 1'b0;
		end else if (ce) begin
			state         <= next_state;
			cycleCnt      <= cycleTick ? 32'h0000_0000 : cycleCnt + 32'h1;
			calcStep      <= 1'b0;
			slavePosValid <= 1'b0;
			torqueValid   <= 1'b0;
			// Watchdog only runs while the link is started; set wins over clear
			if (syncTick | ~ctrlReg[`ESF_CTRL_LINKEN])
				syncCnt <= 32'h0000_0000;
			else if (syncCnt != TIMEOUT_CLKS)
				syncCnt <= syncCnt + 32'h1;
			if (ctrlReg[`ESF_CTRL_LINKEN] & ~syncTick & (syncCnt == TIMEOUT_CLKS - 32'h1))
				syncTimeout <= 1'b1;
			else if (clearTimeout)
				syncTimeout <= 1'b0;
			if (state == `ESF_FSM_IDLE && next_state == `ESF_FSM_FOLLOW) begin
				// Master source, axis and gear ratio frozen here so a live edit of them cannot jolt the slave
				runSel    <= cfgSel;
				runAxis   <= cfgAxis;
				runNum    <= cfgNum;
				runDen    <= cfgDen;
				lastPos   <= startPos;
				prevPos   <= startPos;
				mainAcc   <= 32'sh0000_0000;
				remainder <= 16'sh0000;
				followAck <= 1'b1;
				axisBusy  <= 1'b1;
			end else if (next_state == `ESF_FSM_IDLE) begin
				followAck <= 1'b0;
				axisBusy  <= 1'b0;
			end else if (next_state == `ESF_FSM_STOPPED) begin
				axisBusy  <= 1'b0;
			end
			if (state == `ESF_FSM_FOLLOW && next_state == `ESF_FSM_FOLLOW && cycleTick) begin
				prevPos  <= lastPos;
				lastPos  <= masterOk ? masterNow : lastPos;
				if (masterOk) begin
					mainAcc   <= mainAcc + gearQuot[31:0];
					remainder <= gearRem[15:0];
				end
				calcStep <= 1'b1;
			end
			if (calcStep & (state == `ESF_FSM_FOLLOW)) begin
				slavePos      <= filtOut[31:0];
				slavePosValid <= 1'b1;
				if (ctrlReg[`ESF_CTRL_TORQUE]) begin
					torqueFfOut    <= linkTorqueFf;
					torqueLimitOut <= linkTorqueLimit;
					torqueValid    <= 1'b1;
				end
			end
		end
	end

	// Read side
	always @* begin
		rdHit = 1'b1;
		case (s_axi_araddr)
			`ESF_OFF_CTRL:     rdMux = ctrlReg;
			`ESF_OFF_MASTER:   rdMux = masterReg;
			`ESF_OFF_GEARNUM:  rdMux = gearNumReg;
			`ESF_OFF_GEARDEN:  rdMux = gearDenReg;
			`ESF_OFF_FILTER:   rdMux = filterReg;
			`ESF_OFF_AUXSEL:   rdMux = auxSelReg;
			`ESF_OFF_STATUS:   rdMux = {28'h0, state == `ESF_FSM_STOPPED, syncTimeout,
				axisBusy, followAck};
			`ESF_OFF_SLAVEPOS: rdMux = slavePos;
			`ESF_OFF_MAINPOS:  rdMux = mainAcc;
			`ESF_OFF_REVISION: rdMux = {24'h0, UNIT_REV};
			default: begin
				rdMux = 32'h0000_0000;
				rdHit = 1'b0;
			end
		endcase
	end

	always @(posedge clock) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `ESF_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid & ~s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdMux;
				s_axi_rresp  <= rdHit ? `ESF_RESP_OKAY : `ESF_RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// >>> testbench/esf_follower_properties.sv
// Port assertions for the shaft follower
`default_nettype none
module esf_follower_properties #(
	parameter [31:0] CTRL_CYCLE_CLKS = 32'd8
) (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        syncTick,
	input wire logic [15:0] linkTorqueFf,
	input wire logic [31:0] slavePos,
	input wire logic        slavePosValid,
	input wire logic [15:0] torqueFfOut,
	input wire logic        torqueValid,
	input wire logic        followAck,
	input wire logic        axisBusy,
	input wire logic        syncTimeout,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] sinceTick;
	// Saturates so a long silence never wraps back under the limit
	always_ff @(posedge clock) begin
		if (rst || syncTick)
			sinceTick <= 32'h0;
		else if (sinceTick != 32'hFFFF_FFFF)
			sinceTick <= sinceTick + 32'h1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_quiet;
		!slavePosValid [*7];
	endsequence
	AST_BUSY_ACK: assert property (axisBusy |-> followAck)
		else $error("busy without ack");
	AST_ACK_FALL: assert property ($fell(followAck) |-> !axisBusy)
		else $error("busy after follow end");
	AST_UPD_GAP: assert property (slavePosValid |=> s_quiet)
		else $error("position update spacing wrong");
	AST_POS_HOLD: assert property (!slavePosValid |-> $stable(slavePos))
		else $error("slave position moved off update");
	AST_UPD_FOLLOW: assert property (slavePosValid |-> $past(followAck, 2))
		else $error("update without follow");
	AST_TQ_PAIR: assert property (torqueValid |-> slavePosValid)
		else $error("torque pulse alone");
	AST_TQ_DATA: assert property (torqueValid |-> torqueFfOut == $past(linkTorqueFf))
		else $error("torque data not passed");
	AST_TO_STOP: assert property (syncTimeout |=> !axisBusy)
		else $error("busy after timeout");
	AST_TO_GAP: assert property ($rose(syncTimeout) |-> sinceTick >= 4 * CTRL_CYCLE_CLKS - 2)
		else $error("timeout too early");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
endmodule
bind esf_follower esf_follower_properties #(.CTRL_CYCLE_CLKS(CTRL_CYCLE_CLKS)) u_props (
	.clock(clock), .rst(rst), .syncTick(syncTick), .linkTorqueFf(linkTorqueFf),
	.slavePos(slavePos), .slavePosValid(slavePosValid), .torqueFfOut(torqueFfOut),
	.torqueValid(torqueValid), .followAck(followAck), .axisBusy(axisBusy),
	.syncTimeout(syncTimeout), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
`default_nettype wire

// >>> testbench/esf_master_model.sv
// Master axes, CPU sync pulse and link data
`default_nettype none
module esf_master_model (
	input  wire logic        clock,
	input  wire logic        rst,
	output logic             syncTick,
	output logic [543:0]     feedbackPos,
	output logic [543:0]     commandPos,
	output logic [31:0]      linkAuxPos,
	output logic [15:0]      linkTorqueFf,
	output logic [15:0]      linkTorqueLimit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] cmd [17];
	logic [31:0] fb [17];
	logic        tickOn;
	logic [2:0]  tickCnt;
	initial begin
		syncTick = 1'b0;
		tickOn = 1'b1;
		linkAuxPos = 32'h0;
		linkTorqueFf = 16'h1234;
		linkTorqueLimit = 16'h0456;
		for (int i = 0; i < 17; i++) begin
			cmd[i] = 32'(i) * 32'h100;
			fb[i] = 32'(i) * 32'h300;
		end
	end
	// Pulse only while the CPU side runs
	always @(posedge clock) begin
		tickCnt <= rst ? 3'h0 : tickCnt + 3'h1;
		syncTick <= !rst && tickOn && tickCnt == 3'h7;
	end
	always_comb begin
		for (int i = 0; i < 17; i++) begin
			commandPos[i*32+:32] = cmd[i];
			feedbackPos[i*32+:32] = fb[i];
		end
	end
	// Master moves only after follow is set up
	task automatic move(input logic isFb, input int ax, input logic [31:0] d);
		if (isFb)
			fb[ax] <= fb[ax] + d;
		else
			cmd[ax] <= cmd[ax] + d;
	endtask
	task automatic setAux(input logic [31:0] v);
		linkAuxPos <= v;
	endtask
endmodule
`default_nettype wire

// >>> testbench/esf_tb.sv
// Register-level bench for the shaft follower
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CYC = 8;
	logic        clock, rst;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata;
	wire         awready, wready, bvalid, arready, rvalid, posValid, tqValid;
	wire         followAck, axisBusy, syncTimeout, syncTick;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata, slavePos, auxPos;
	wire [15:0]  tqFf, tqLim, lTqFf, lTqLim;
	wire [543:0] fbPos, cmdPos;
	int          n_mismatch, checks_done;
	esf_follower #(.CTRL_CYCLE_CLKS(CYC)) u_dut (.clock(clock), .rst(rst), .ce(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.syncTick(syncTick), .feedbackPos(fbPos), .commandPos(cmdPos), .linkAuxPos(auxPos),
		.linkTorqueFf(lTqFf), .linkTorqueLimit(lTqLim), .slavePos(slavePos),
		.slavePosValid(posValid), .torqueFfOut(tqFf), .torqueLimitOut(tqLim),
		.torqueValid(tqValid), .followAck(followAck), .axisBusy(axisBusy),
		.syncTimeout(syncTimeout));
	esf_master_model u_model (.clock(clock), .rst(rst), .syncTick(syncTick),
		.feedbackPos(fbPos), .commandPos(cmdPos), .linkAuxPos(auxPos),
		.linkTorqueFf(lTqFf), .linkTorqueLimit(lTqLim));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic settle;
		cyc(2);
		@(negedge clock);
	endtask
	task automatic hung;
		n_mismatch++;
		complete_run();
	endtask
	// Handshakes judged on the values that stood at the rising edge itself
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clock);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				return;
			end
		end
		hung();
	endtask
	task automatic axiRd(input logic [7:0] a, output logic [1:0] r, output logic [31:0] d);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clock);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				r = rresp;
				d = rdata;
				rready <= 1'b0;
				return;
			end
		end
		hung();
	endtask
	task automatic follow(input logic [31:0] msel, num, den, input logic isFb, input int ax,
		input logic [31:0] d1, d2, exp);
		logic [31:0] p0;
		logic [1:0]  r;
		axiWr(8'h04, msel, r);
		axiWr(8'h08, num, r);
		axiWr(8'h0C, den, r);
		axiWr(8'h00, 32'h11, r);
		settle();
		chk({followAck, axisBusy}, 2'b11);
		cyc(3 * CYC);
		@(negedge clock);
		p0 = slavePos;
		@(posedge clock);
		u_model.move(isFb, ax, d1);
		cyc(2 * CYC);
		u_model.move(isFb, ax, d2);
		cyc(4 * CYC);
		@(negedge clock);
		chk(32'(slavePos - p0), exp);
		axiWr(8'h00, 32'h10, r);
		settle();
		chk({followAck, axisBusy}, 2'b00);
	endtask
	logic [7:0]  rA [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h24, 8'h40};
	logic [33:0] rE [9] = '{0, 0, 0, 0, 34'h100, 0, 0, 34'h15, 34'h200000000};
	logic [31:0] tM [8] = '{32'h204, 32'h204, 32'h1003, 32'h204, 32'h200, 32'h1104, 32'h204,
		32'h204};
	int          tN [8] = '{3, 2, 1, -1, 3, 3, 20000, 3};
	int          tD [8] = '{2, 0, 3, 3, 1, 1, 1, 1};
	logic        tF [8] = '{0, 0, 1, 0, 0, 0, 0, 1};
	int          tA [8] = '{2, 2, 16, 2, 2, 2, 2, 2};
	int          t1 [8] = '{10, 7, 5, 5, 10, 10, 1, 10};
	int          t2 [8] = '{0, 0, 4, 4, 0, 0, 0, 0};
	int          tX [8] = '{15, 14, 3, -3, 0, 0, 10000, 0};
	initial begin
		logic [1:0]  r;
		logic [31:0] d, p0;
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		cyc(5);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			axiRd(rA[i], r, d);
			chk({r, d}, rE[i]);
		end
		axiWr(8'h40, 32'h1, r);
		chk(r, 2'h2);
		for (int i = 0; i < 8; i++)
			follow(tM[i], tN[i], tD[i], tF[i], tA[i], t1[i], t2[i], tX[i]);
		axiWr(8'h14, 32'h1, r);
		axiWr(8'h10, 32'h200, r);
		axiWr(8'h00, 32'h19, r);
		settle();
		p0 = slavePos;
		u_model.setAux(32'd100);
		cyc(4 * CYC);
		@(negedge clock);
		chk(slavePos - p0, 32'd200);
		chk(tqFf, 16'h1234);
		axiWr(8'h00, 32'h13, r);
		settle();
		chk({followAck, axisBusy}, 2'b10);
		p0 = slavePos;
		u_model.move(1'b0, 2, 32'd10);
		cyc(4 * CYC);
		@(negedge clock);
		chk(slavePos - p0, 32'h0);
		axiWr(8'h00, 32'h10, r);
		u_model.tickOn <= 1'b0;
		axiWr(8'h00, 32'h11, r);
		cyc(6 * CYC);
		settle();
		chk({syncTimeout, axisBusy}, 2'b10);
		u_model.tickOn <= 1'b1;
		cyc(2 * CYC);
		axiWr(8'h18, 32'h4, r);
		axiWr(8'h00, 32'h10, r);
		settle();
		chk(syncTimeout, 1'b0);
		complete_run();
	end
endmodule
`default_nettype wire
